// *** common_voltage_code_i2c_checker.sv ***
// Purpose: port-level assertions for the common-voltage I2C target
// Assumes: one clk_sys domain, rst asynchronous and active high
// Notes:   attached to the top module by the bind at the foot of this file
`timescale 1ns/10ps
module common_voltage_code_i2c_checker
    import common_voltage_code_i2c_pkg::*;
#(
    parameter int unsigned NV_CYCLES = NV_WRITE_CYCLES,
    parameter int unsigned FILT_CYC  = FILTER_CYCLES
)
(
    input wire logic              clk_sys,
    input wire logic              rst,
    input wire logic              scl_in,
    input wire logic              sda_in,
    input wire logic              sda_out,
    input wire logic              sda_oe,
    input wire logic [CODE_W-1:0] common_voltage_code,
    input wire logic [7:0]        calibrator_output_current,
    input wire logic [CODE_W-1:0] nv_code,
    input wire logic              codes_differ,
    input wire logic              nv_busy
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    logic [31:0] busy_cnt_r;
    logic [31:0] busy_cnt_nxt;

    always_comb
    begin
        busy_cnt_nxt = nv_busy ? busy_cnt_r + 32'h1 : 32'h0;
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            busy_cnt_r <= 32'h0;
        else
            busy_cnt_r <= busy_cnt_nxt;
    end

    ////////////////////////////////////////////////////////////////////////////
    sequence s_code_held;
        $stable(common_voltage_code) ##1 $stable(common_voltage_code);
    endsequence

    sequence s_busy_run;
        nv_busy[*8];
    endsequence

    a_current_from_code: assert property (s_code_held |->
        calibrator_output_current == {1'b0, common_voltage_code} + 8'h01)
        else $error("output current does not follow the code");
    a_open_drain_only: assert property (sda_out == 1'b0)
        else $error("sda driven high");
    a_busy_min_run: assert property ($rose(nv_busy) |-> s_busy_run)
        else $error("program cycle ended too early");
    a_busy_bounded: assert property (busy_cnt_r <= NV_CYCLES + 4)
        else $error("program cycle overran");
    // the data-byte ack rises one cycle before busy; the check skips the first 16 busy cycles
    a_busy_no_ack: assert property (nv_busy && $past(nv_busy, 16) |-> !$rose(sda_oe))
        else $error("target answered while programming");
    a_nv_moves_busy: assert property (!$stable(nv_code) |-> nv_busy || $past(nv_busy))
        else $error("non-volatile copy changed outside a program cycle");
    a_settle_match: assert property ($fell(nv_busy) |-> ##[0:2] (nv_code == common_voltage_code))
        else $error("copies differ after program cycle");
    a_differ_flag: assert property ($stable(common_voltage_code) && $stable(nv_code) |->
        codes_differ == (common_voltage_code != nv_code))
        else $error("difference flag wrong");
    a_ack_release: assert property ($rose(sda_oe) |-> ##[1:1000] !sda_oe)
        else $error("sda held low too long");
endmodule

bind common_voltage_code_i2c_program_slave common_voltage_code_i2c_checker #(
    .NV_CYCLES (NV_CYCLES),
    .FILT_CYC  (FILT_CYC)
) i_common_voltage_code_i2c_checker (
    .clk_sys                   (clk_sys),
    .rst                       (rst),
    .scl_in                    (scl_in),
    .sda_in                    (sda_in),
    .sda_out                   (sda_out),
    .sda_oe                    (sda_oe),
    .common_voltage_code       (common_voltage_code),
    .calibrator_output_current (calibrator_output_current),
    .nv_code                   (nv_code),
    .codes_differ              (codes_differ),
    .nv_busy                   (nv_busy)
);

// *** common_voltage_code_i2c_pkg.sv ***
// Purpose: shared constants and types of the common-voltage I2C target
// Assumes: system clock of 25 MHz, open-drain bus pins
// Notes:   every offset, field position, code reset value and design timing count lives here; bus idle levels are set where used
package common_voltage_code_i2c_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // bus addressing
    localparam logic [6:0] TARGET_ADDR7   = 7'h4f;
    localparam logic [7:0] ADDR_BYTE_WR   = 8'h9e;
    localparam logic [7:0] ADDR_BYTE_RD   = 8'h9f;
    localparam int         RW_BIT         = 0;
    localparam logic [3:0] BITS_PER_BYTE  = 4'h8;

    ////////////////////////////////////////////////////////////////////////////
    // common_voltage_setting field layout
    localparam int         CODE_MSB       = 7;
    localparam int         CODE_LSB       = 1;
    localparam int         CODE_W         = CODE_MSB - CODE_LSB + 1;
    localparam int         DEST_BIT       = 0;
    localparam logic       DEST_DAC_NV    = 1'b0;
    localparam logic       DEST_DAC_ONLY  = 1'b1;
    localparam logic       FLAG_SAME      = 1'b0;
    localparam logic       FLAG_DIFF      = 1'b1;
    localparam int         CODE_STEPS     = 128;
    localparam logic [6:0] CODE_RESET     = 7'h00;
    localparam logic [7:0] STEP_ONE       = 8'h01;

    ////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int         CLK_FREQ_MHZ     = 25;
    localparam int         NV_WRITE_TIME_US = 5000;
    localparam int         NV_WRITE_CYCLES  = NV_WRITE_TIME_US * CLK_FREQ_MHZ;
    localparam int         SPIKE_TIME_NS    = 50;
    localparam int         CLK_PERIOD_NS    = 1000 / CLK_FREQ_MHZ;
    localparam int         FILTER_CYCLES    = (SPIKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////////
    // target protocol states
    typedef enum logic [2:0] {
        ST_IDLE      = 3'b000,
        ST_ADDR      = 3'b001,
        ST_ADDR_ACK  = 3'b010,
        ST_WDATA     = 3'b011,
        ST_WDATA_ACK = 3'b100,
        ST_RDATA     = 3'b101,
        ST_RDATA_ACK = 3'b110
    } target_state_t;

endpackage

// *** common_voltage_code_i2c_program_slave.sv ***
// Purpose: single-byte I2C target that programs the common-voltage calibration DAC
// Assumes: scl_in and sda_in come straight from pins; sda is open drain
// Notes:   the target never drives scl and never stretches the clock
//
// Summary of operation
// R1: written data byte bits 7..1 carry the 7-bit calibration code.
// R2: read byte bits 7..1 return the stored non-volatile code.
// R3: current steps equal code plus one, out of 128.
// R4: destination bit 0 low updates DAC register and non-volatile copy.
// R5: destination bit 0 high updates only the DAC register.
// R6: read bit 0 is 0 when copies match, 1 when they differ.
// R7: answer address byte 9E for writes and 9F for reads.
// R8: master sends START, address, one data byte, STOP; each byte acknowledged.
// R9: read returns one byte after address ack; master then NACKs and STOPs.
// R10: differing-copy read example conflicts with R2; non-volatile code returned.
// R11: target only, working at both 100 and 400 kbps.
// R12: ignore addressing while a non-volatile write is still completing.
// R13: master must not START again mid-address; here that simply restarts.
// R14: stay busy until the non-volatile copy matches the DAC register.
`timescale 1ns/10ps
module common_voltage_code_i2c_program_slave
    import common_voltage_code_i2c_pkg::*;
#(
    parameter int unsigned NV_CYCLES = NV_WRITE_CYCLES,
    parameter int unsigned FILT_CYC  = FILTER_CYCLES
)
(
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire logic              scl_in,
    input  wire logic              sda_in,
    output logic                   sda_out,
    output logic                   sda_oe,
    output logic [CODE_W-1:0]      common_voltage_code,
    output logic [7:0]             calibrator_output_current,
    output logic [CODE_W-1:0]      nv_code,
    output logic                   codes_differ,
    output logic                   nv_busy
);

    localparam int FW = $clog2(FILT_CYC + 1);
    localparam logic [FW-1:0] FILT_LAST = FW'(FILT_CYC);

    initial
    begin
        if (FILT_CYC < 1 || FILT_CYC > 8)
            $error("common_voltage_code_i2c_program_slave: FILT_CYC must lie in 1..8");
        if (NV_CYCLES < 1)
            $error("common_voltage_code_i2c_program_slave: NV_CYCLES must be at least 1");
        if (CODE_STEPS != (1 << CODE_W))
            $error("common_voltage_code_i2c_program_slave: code width does not match step count");
    end

    function automatic logic addr_hit(input logic [7:0] b);
        addr_hit = (b[7:1] == TARGET_ADDR7);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and spike filter
    logic [1:0]    pins_s;
    logic [FW-1:0] scl_cnt_r, scl_cnt_nxt, sda_cnt_r, sda_cnt_nxt;
    logic          scl_f_r, scl_f_nxt, sda_f_r, sda_f_nxt;
    logic          scl_d_r, sda_d_r;

    pin_sync #(.WIDTH(2)) u_sync
    (
        .clk_sys (clk_sys),
        .rst     (rst),
        .d       ({scl_in, sda_in}),
        .q       (pins_s)
    );

    // a level change is taken only after it stands FILT_CYC cycles; this kills
    // fast-mode spikes at the cost of that much extra latency per edge
    always_comb
    begin
        scl_cnt_nxt = scl_cnt_r;
        scl_f_nxt   = scl_f_r;
        sda_cnt_nxt = sda_cnt_r;
        sda_f_nxt   = sda_f_r;
        if (pins_s[1] == scl_f_r)
            scl_cnt_nxt = '0;
        else if (scl_cnt_r == FILT_LAST - FW'(1))
        begin
            scl_cnt_nxt = '0;
            scl_f_nxt   = pins_s[1];
        end
        else
            scl_cnt_nxt = scl_cnt_r + FW'(1);
        if (pins_s[0] == sda_f_r)
            sda_cnt_nxt = '0;
        else if (sda_cnt_r == FILT_LAST - FW'(1))
        begin
            sda_cnt_nxt = '0;
            sda_f_nxt   = pins_s[0];
        end
        else
            sda_cnt_nxt = sda_cnt_r + FW'(1);
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            scl_cnt_r <= '0;
            sda_cnt_r <= '0;
            scl_f_r   <= 1'b1;
            sda_f_r   <= 1'b1;
            scl_d_r   <= 1'b1;
            sda_d_r   <= 1'b1;
        end
        else
        begin
            scl_cnt_r <= scl_cnt_nxt;
            sda_cnt_r <= sda_cnt_nxt;
            scl_f_r   <= scl_f_nxt;
            sda_f_r   <= sda_f_nxt;
            scl_d_r   <= scl_f_r;
            sda_d_r   <= sda_f_r;
        end
    end

    logic scl_rise, scl_fall, bus_start, bus_stop;

    assign scl_rise  = scl_f_r & ~scl_d_r;
    assign scl_fall  = ~scl_f_r & scl_d_r;
    assign bus_start = scl_f_r & scl_d_r & sda_d_r & ~sda_f_r;
    assign bus_stop  = scl_f_r & scl_d_r & ~sda_d_r & sda_f_r;

    ////////////////////////////////////////////////////////////////////////////
    // non-volatile copy
    logic              nv_wr_req_r, nv_wr_req_nxt;
    logic [CODE_W-1:0] nv_wr_data_r, nv_wr_data_nxt;

    nv_store #(.WRITE_CYCLES(NV_CYCLES)) u_nv
    (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .wr_req    (nv_wr_req_r),
        .wr_data   (nv_wr_data_r),
        .rd_data_r (nv_code),
        .busy_r    (nv_busy)
    );

    ////////////////////////////////////////////////////////////////////////////
    // protocol engine
    target_state_t     state_r, state_nxt;
    logic [3:0]        bit_cnt_r, bit_cnt_nxt;
    logic [7:0]        shift_r, shift_nxt;
    logic              rd_mode_r, rd_mode_nxt;
    logic              sda_oe_nxt;
    logic [CODE_W-1:0] dac_r, dac_nxt;

    always_comb
    begin
        state_nxt      = state_r;
        bit_cnt_nxt    = bit_cnt_r;
        shift_nxt      = shift_r;
        rd_mode_nxt    = rd_mode_r;
        sda_oe_nxt     = sda_oe;
        dac_nxt        = dac_r;
        nv_wr_req_nxt  = 1'b0;
        nv_wr_data_nxt = nv_wr_data_r;
        if (bus_stop)
        begin
            state_nxt  = ST_IDLE;
            sda_oe_nxt = 1'b0;
        end
        else if (bus_start)
        begin
            // a START at any point, even mid-address, restarts cleanly
            state_nxt   = ST_ADDR; // R13
            bit_cnt_nxt = '0;
            sda_oe_nxt  = 1'b0;
        end
        else
        begin
            case (state_r)
                ST_IDLE:
                begin
                    sda_oe_nxt = 1'b0;
                end
                ST_ADDR:
                begin
                    if (scl_rise)
                    begin
                        shift_nxt   = {shift_r[6:0], sda_f_r};
                        bit_cnt_nxt = bit_cnt_r + 4'h1;
                    end
                    else if (scl_fall && bit_cnt_r == BITS_PER_BYTE)
                    begin
                        if (addr_hit(shift_r) && !nv_busy) // R7 R12
                        begin
                            rd_mode_nxt = shift_r[RW_BIT];
                            sda_oe_nxt  = 1'b1;
                            state_nxt   = ST_ADDR_ACK;
                        end
                        else
                            state_nxt = ST_IDLE;
                    end
                end
                ST_ADDR_ACK:
                begin
                    if (scl_fall)
                    begin
                        bit_cnt_nxt = '0;
                        if (rd_mode_r)
                        begin
                            // non-volatile code plus mismatch flag
                            shift_nxt  = {nv_code,
                                          (nv_code != dac_r) ? FLAG_DIFF : FLAG_SAME}; // R2 R6 R10
                            sda_oe_nxt = ~shift_nxt[7]; // R9
                            state_nxt  = ST_RDATA;
                        end
                        else
                        begin
                            sda_oe_nxt = 1'b0;
                            state_nxt  = ST_WDATA;
                        end
                    end
                end
                ST_WDATA:
                begin
                    if (scl_rise)
                    begin
                        shift_nxt   = {shift_r[6:0], sda_f_r};
                        bit_cnt_nxt = bit_cnt_r + 4'h1;
                    end
                    else if (scl_fall && bit_cnt_r == BITS_PER_BYTE)
                    begin
                        sda_oe_nxt = 1'b1; // R8
                        state_nxt  = ST_WDATA_ACK;
                        dac_nxt    = shift_r[CODE_MSB:CODE_LSB]; // R1 R5
                        if (shift_r[DEST_BIT] == DEST_DAC_NV)
                        begin
                            nv_wr_req_nxt  = 1'b1; // R4 R14
                            nv_wr_data_nxt = shift_r[CODE_MSB:CODE_LSB];
                        end
                    end
                end
                ST_WDATA_ACK:
                begin
                    // one data byte only: later bytes are left unacknowledged
                    if (scl_fall)
                    begin
                        sda_oe_nxt = 1'b0;
                        state_nxt  = ST_IDLE; // R8
                    end
                end
                ST_RDATA:
                begin
                    if (scl_rise)
                        bit_cnt_nxt = bit_cnt_r + 4'h1;
                    else if (scl_fall)
                    begin
                        if (bit_cnt_r == BITS_PER_BYTE)
                        begin
                            sda_oe_nxt = 1'b0;
                            state_nxt  = ST_RDATA_ACK;
                        end
                        else
                        begin
                            shift_nxt  = {shift_r[6:0], 1'b0};
                            sda_oe_nxt = ~shift_nxt[7];
                        end
                    end
                end
                ST_RDATA_ACK:
                begin
                    // a single byte is offered whether the master acks or not
                    if (scl_rise)
                        state_nxt = ST_IDLE; // R9
                end
                default:
                begin
                    state_nxt  = ST_IDLE;
                    sda_oe_nxt = 1'b0;
                end
            endcase
        end
    end

    // sda changes a few cycles after scl falls, well inside fast-mode valid time
    always_ff @(posedge clk_sys or posedge rst) // R11
    begin
        if (rst)
        begin
            state_r      <= ST_IDLE;
            bit_cnt_r    <= '0;
            shift_r      <= '0;
            rd_mode_r    <= 1'b0;
            sda_oe       <= 1'b0;
            dac_r        <= CODE_RESET;
            nv_wr_req_r  <= 1'b0;
            nv_wr_data_r <= CODE_RESET;
        end
        else
        begin
            state_r      <= state_nxt;
            bit_cnt_r    <= bit_cnt_nxt;
            shift_r      <= shift_nxt;
            rd_mode_r    <= rd_mode_nxt;
            sda_oe       <= sda_oe_nxt;
            dac_r        <= dac_nxt;
            nv_wr_req_r  <= nv_wr_req_nxt;
            nv_wr_data_r <= nv_wr_data_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // DAC-side outputs
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            sda_out                   <= 1'b0;
            common_voltage_code       <= CODE_RESET;
            calibrator_output_current <= STEP_ONE;
            codes_differ              <= FLAG_SAME;
        end
        else
        begin
            sda_out                   <= 1'b0;
            common_voltage_code       <= dac_r;
            calibrator_output_current <= {1'b0, dac_r} + STEP_ONE; // R3
            codes_differ              <= (nv_code != dac_r) ? FLAG_DIFF : FLAG_SAME; // R6
        end
    end

endmodule

// *** host_model.sv ***
// Purpose: behavioural I2C bus master for the common-voltage target
// Assumes: q clk_sys cycles per quarter bit, set by the bench
// Notes:   changes lines just after a clock edge; scl idles high between frames
`timescale 1ns/10ps
module host_model
(
    input  wire logic clk_sys,
    input  wire logic sda_bus,
    output logic      scl,
    output logic      sda_drv
);
    int q;

    initial
    begin
        q = 16;
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    task automatic tick();
        repeat (q) @(posedge clk_sys);
    endtask

    // releases both lines first, so it also serves as a repeated start
    task automatic start();
        sda_drv <= 1'b1;
        tick();
        scl <= 1'b1;
        tick();
        sda_drv <= 1'b0;
        tick();
        scl <= 1'b0;
        tick();
    endtask

    task automatic stop();
        sda_drv <= 1'b0;
        tick();
        scl <= 1'b1;
        tick();
        sda_drv <= 1'b1;
        tick();
        tick();
    endtask

    // eight bits MSB first, then the ninth bit: mack is driven, ack is sampled
    task automatic xfer(input logic [7:0] tx, input logic mack,
                        output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= -1; i--)
        begin
            sda_drv <= (i < 0) ? mack : tx[i];
            tick();
            scl <= 1'b1;
            tick();
            if (i >= 0)
                rx[i] = sda_bus;
            else
                ack = ~sda_bus;
            tick();
            scl <= 1'b0;
            tick();
        end
    endtask
endmodule

// *** nv_store.sv ***
// Purpose: one-word non-volatile copy of the calibration code with a timed program cycle
// Assumes: writes are not requested while busy_r is high
// Notes:   the stored word is itself the read register
`timescale 1ns/10ps
module nv_store
    import common_voltage_code_i2c_pkg::*;
#(
    parameter int unsigned WRITE_CYCLES = NV_WRITE_CYCLES
)
(
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire logic              wr_req,
    input  wire logic [CODE_W-1:0] wr_data,
    output logic      [CODE_W-1:0] rd_data_r,
    output logic                   busy_r
);

    localparam int CNT_W = $clog2(WRITE_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(WRITE_CYCLES - 1);

    logic [CNT_W-1:0]  cnt_r;
    logic [CNT_W-1:0]  cnt_nxt;
    logic [CODE_W-1:0] pend_r;
    logic [CODE_W-1:0] pend_nxt;
    logic [CODE_W-1:0] rd_data_nxt;
    logic              busy_nxt;

    initial
    begin
        if (WRITE_CYCLES < 1)
            $error("nv_store: WRITE_CYCLES must be at least 1");
    end

    always_comb
    begin
        cnt_nxt     = cnt_r;
        pend_nxt    = pend_r;
        rd_data_nxt = rd_data_r;
        busy_nxt    = busy_r;
        if (!busy_r)
        begin
            if (wr_req)
            begin
                pend_nxt = wr_data;
                cnt_nxt  = '0;
                busy_nxt = 1'b1;
            end
        end
        else if (cnt_r == CNT_LAST)
        begin
            // copy lands and busy drops in the same edge, so busy never
            // ends while the copy still differs from the written code
            rd_data_nxt = pend_r;
            busy_nxt    = 1'b0;
        end
        else
        begin
            cnt_nxt = cnt_r + CNT_W'(1);
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            cnt_r     <= '0;
            pend_r    <= CODE_RESET;
            rd_data_r <= CODE_RESET;
            busy_r    <= 1'b0;
        end
        else
        begin
            cnt_r     <= cnt_nxt;
            pend_r    <= pend_nxt;
            rd_data_r <= rd_data_nxt;
            busy_r    <= busy_nxt;
        end
    end

endmodule

// *** pin_sync.sv ***
// Purpose: two-flop synchroniser for asynchronous pin inputs
// Assumes: inputs are levels, not pulses
// Notes:   the first stage feeds only the second stage
`timescale 1ns/10ps
module pin_sync
#(
    parameter int WIDTH = 2
)
(
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_r;

    initial
    begin
        if (WIDTH < 1)
            $error("pin_sync: WIDTH must be at least 1");
    end

    // reset to the idle bus level so no false START appears after reset
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            meta_r <= '1;
            q      <= '1;
        end
        else
        begin
            meta_r <= d;
            q      <= meta_r;
        end
    end

endmodule

// *** tb.sv ***
// Purpose: self-checking bench for the common-voltage I2C target
// Assumes: program cycle shortened to NV_SIM cycles
// Notes:   sda is open drain: low when either party pulls it
`timescale 1ns/10ps
module tb
    import common_voltage_code_i2c_pkg::*;
();
    localparam int unsigned NV_SIM = 2000;

    logic              clk_sys;
    logic              rst;
    logic              scl;
    logic              sda_drv;
    logic              sda_bus;
    logic              sda_out;
    logic              sda_oe;
    logic              codes_differ;
    logic              nv_busy;
    logic [CODE_W-1:0] common_voltage_code;
    logic [CODE_W-1:0] nv_code;
    logic [7:0]        calibrator_output_current;
    int                err_count;
    int                total_checks;
    logic [7:0]        dac_tab [3] = '{8'hef, 8'hff, 8'h01};
    logic [7:0]        bad_tab [3] = '{8'h9c, 8'h1e, 8'hde};

    assign sda_bus = sda_drv & ~(sda_oe & ~sda_out);
    always #20 clk_sys = ~clk_sys;

    common_voltage_code_i2c_program_slave #(.NV_CYCLES(NV_SIM)) i_common_voltage_code_i2c_program_slave (
        .clk_sys (clk_sys), .rst (rst), .scl_in (scl), .sda_in (sda_bus),
        .sda_out (sda_out), .sda_oe (sda_oe),
        .common_voltage_code (common_voltage_code),
        .calibrator_output_current (calibrator_output_current),
        .nv_code (nv_code), .codes_differ (codes_differ), .nv_busy (nv_busy));

    host_model i_host_model (
        .clk_sys (clk_sys), .sda_bus (sda_bus), .scl (scl), .sda_drv (sda_drv));

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        total_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic addr_try(input logic [7:0] a, input logic exp_ack);
        logic [7:0] rx;
        logic       ack;
        i_host_model.start();
        i_host_model.xfer(a, 1'b1, rx, ack);
        check({7'h00, ack}, {7'h00, exp_ack}, "address answer");
        i_host_model.stop();
    endtask

    task automatic wr(input logic [7:0] d, input logic extra);
        logic [7:0] rx;
        logic       ack;
        i_host_model.start();
        i_host_model.xfer(ADDR_BYTE_WR, 1'b1, rx, ack);
        check({7'h00, ack}, 8'h01, "write address ack");
        i_host_model.xfer(d, 1'b1, rx, ack);
        check({7'h00, ack}, 8'h01, "data ack");
        if (extra)
        begin
            i_host_model.xfer(8'h5a, 1'b1, rx, ack);
            check({7'h00, ack}, 8'h00, "extra byte refused");
        end
        i_host_model.stop();
    endtask

    task automatic rd(input logic [7:0] exp);
        logic [7:0] rx;
        logic       ack;
        i_host_model.start();
        i_host_model.xfer(ADDR_BYTE_RD, 1'b1, rx, ack);
        check({7'h00, ack}, 8'h01, "read address ack");
        i_host_model.xfer(8'hff, 1'b1, rx, ack);
        check(rx, exp, "read byte");
        i_host_model.stop();
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk_sys = 1'b0;
        rst = 1'b1;
        err_count = 0;
        total_checks = 0;
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (20) @(posedge clk_sys);
        check({1'b0, common_voltage_code}, 8'h00, "reset code");
        check(calibrator_output_current, 8'h01, "reset current");
        check({codes_differ, nv_code}, 8'h00, "reset copies");
        check({7'h00, nv_busy}, 8'h00, "reset busy");
        rd(8'h00);
        $display("test reset done");
        foreach (dac_tab[i])
        begin
            wr(dac_tab[i], 1'b0);
            repeat (10) @(posedge clk_sys);
            check({1'b0, common_voltage_code}, {1'b0, dac_tab[i][7:1]}, "dac code");
            check(calibrator_output_current, {1'b0, dac_tab[i][7:1]} + 8'h01, "current");
            check({nv_busy, nv_code}, 8'h00, "nv untouched");
            rd({7'h00, dac_tab[i][7:1] != 7'h00});
        end
        $display("test dac only done");
        wr(8'hee, 1'b1);
        check({7'h00, nv_busy}, 8'h01, "busy after program");
        check({7'h00, codes_differ}, 8'h01, "differ while busy");
        addr_try(ADDR_BYTE_RD, 1'b0);
        for (int n = 0; n < 4000 && nv_busy !== 1'b0; n++)
            @(posedge clk_sys);
        repeat (3) @(posedge clk_sys);
        check({7'h00, nv_busy}, 8'h00, "busy cleared");
        check({1'b0, nv_code}, 8'h77, "nv copy");
        check({7'h00, codes_differ}, 8'h00, "copies equal");
        rd(8'hee);
        $display("test program done");
        foreach (bad_tab[i])
            addr_try(bad_tab[i], 1'b0);
        $display("test foreign address done");
        i_host_model.q = 63;
        wr(8'h2b, 1'b0);
        rd(8'hef);
        $display("test standard rate done");
        test_done();
    end

    initial
    begin
        // about twice the expected run of some 25000 clk_sys cycles
        #2000000;
        err_count++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        test_done();
    end
endmodule
